// file: include/cpdc_consts.svh
// timing counts and widths for the conversion and power-down control
`ifndef CPDC_CONSTS_SVH
`define CPDC_CONSTS_SVH
`define CPDC_NUM_CH 8
`define CPDC_SPAN_W 3
`define CPDC_CONV_TIME_NS 4000
`define CPDC_CLK_PERIOD_NS 100
`define CPDC_CONV_CYCLES ((`CPDC_CONV_TIME_NS + `CPDC_CLK_PERIOD_NS - 1) / `CPDC_CLK_PERIOD_NS)
`define CPDC_CNT_W 8
`define CPDC_SPAN_DISABLED 3'h0
`endif

// file: include/cpdc_pkg.sv
// types for the conversion and power-down control
package cpdc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_PDN = 3'b100
    } cpdc_state_t;

    typedef struct packed {
        logic busy;
        logic hold;
        logic powered_down;
    } cpdc_status_t;
endpackage : cpdc_pkg

// file: core/cpdc_top.sv
// conversion start, busy, power-down and global reset control
`timescale 1ns/1ns
`include "cpdc_consts.svh"
module cpdc_top #(
    parameter int CONV_CYCLES = `CPDC_CONV_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // host pins
    input wire logic CONVERSION_START_IN,
    input wire logic POWER_DOWN_IN,
    input wire logic MODE_LVDS_IN,
    input wire logic CHIP_SELECT_B_IN,
    input wire logic [`CPDC_NUM_CH*`CPDC_SPAN_W-1:0] SPAN_CODES_IN,
    input wire logic ECHO_CLOCK_TOGGLE,
    // status outputs
    output logic BUSY,
    output logic [`CPDC_NUM_CH-1:0] HOLD_CH,
    output logic [`CPDC_NUM_CH*`CPDC_SPAN_W-1:0] SPAN_LATCHED,
    output logic [`CPDC_NUM_CH-1:0] CH_ENABLED,
    output logic MODE_LVDS,
    output logic POWERED_DOWN,
    output logic GLOBAL_RESET,
    output logic ECHOED_SERIAL_CLOCK_OUT
);
    logic [1:0] cnv_sync;
    logic [1:0] pd_sync;
    logic [1:0] mode_sync;
    logic [1:0] cs_sync;
    logic cnv_prev;
    logic pd_prev;
    logic cnv_rise;
    logic pd_rise;
    logic pd_armed;
    logic soft_rst;
    logic rst_any;
    logic [`CPDC_CNT_W-1:0] cnt;
    logic busy_prev;
    cpdc_pkg::cpdc_state_t state;
    cpdc_pkg::cpdc_status_t status;

    function automatic logic span_on(input logic [`CPDC_SPAN_W-1:0] code);
        span_on = (code != `CPDC_SPAN_DISABLED);
    endfunction : span_on

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            cnv_sync <= 2'h0;
            pd_sync <= 2'h0;
            mode_sync <= 2'h0;
            // chip select resets to its deselected level
            cs_sync <= 2'h3;
            cnv_prev <= 1'b0;
            pd_prev <= 1'b0;
        end
        else
        begin
            cnv_sync <= {cnv_sync[0], CONVERSION_START_IN};
            pd_sync <= {pd_sync[0], POWER_DOWN_IN};
            mode_sync <= {mode_sync[0], MODE_LVDS_IN};
            cs_sync <= {cs_sync[0], CHIP_SELECT_B_IN};
            cnv_prev <= cnv_sync[1];
            pd_prev <= pd_sync[1];
        end
    end

    // chip select is deliberately not part of the start edge
    assign cnv_rise = cnv_sync[1] & ~cnv_prev;
    assign pd_rise = pd_sync[1] & ~pd_prev;
    assign soft_rst = pd_rise & pd_armed & (state != cpdc_pkg::ST_CONV);
    assign rst_any = !RST_B || GLOBAL_RESET;

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
            GLOBAL_RESET <= 1'b0;
        else
            GLOBAL_RESET <= soft_rst;
    end

    // second power-down raise with no conversion between triggers reset
    always_ff @(posedge CLK)
    begin
        if (rst_any)
            pd_armed <= 1'b0;
        else if (pd_rise)
            pd_armed <= 1'b1;
        else if (state == cpdc_pkg::ST_IDLE && cnv_rise && !pd_sync[1])
            pd_armed <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (rst_any)
        begin
            state <= cpdc_pkg::ST_IDLE;
            cnt <= '0;
        end
        else
        begin
            unique case (state)
                cpdc_pkg::ST_IDLE:
                begin
                    if (pd_sync[1])
                        state <= cpdc_pkg::ST_PDN;
                    else if (cnv_rise)
                    begin
                        state <= cpdc_pkg::ST_CONV;
                        cnt <= `CPDC_CNT_W'(CONV_CYCLES - 1);
                    end
                end
                cpdc_pkg::ST_CONV:
                begin
                    // further start edges are not looked at here
                    if (cnt == '0)
                        state <= pd_sync[1] ? cpdc_pkg::ST_PDN : cpdc_pkg::ST_IDLE;
                    else
                        cnt <= cnt - 1'b1;
                end
                cpdc_pkg::ST_PDN:
                begin
                    if (!pd_sync[1])
                        state <= cpdc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign status.busy = (state == cpdc_pkg::ST_CONV);
    assign status.hold = (state == cpdc_pkg::ST_CONV);
    assign status.powered_down = (state == cpdc_pkg::ST_PDN);

    always_ff @(posedge CLK)
    begin
        if (rst_any)
        begin
            BUSY <= 1'b0;
            HOLD_CH <= '0;
            POWERED_DOWN <= 1'b0;
            busy_prev <= 1'b0;
        end
        else
        begin
            BUSY <= status.busy;
            HOLD_CH <= {`CPDC_NUM_CH{status.hold}};
            POWERED_DOWN <= status.powered_down;
            busy_prev <= BUSY;
        end
    end

    // span codes are captured per channel at each conversion start
    always_ff @(posedge CLK)
    begin
        if (rst_any)
        begin
            SPAN_LATCHED <= '1;
            CH_ENABLED <= '1;
        end
        else if (state == cpdc_pkg::ST_IDLE && cnv_rise && !pd_sync[1])
        begin
            SPAN_LATCHED <= SPAN_CODES_IN;
            for (int i = 0; i < `CPDC_NUM_CH; i++)
                CH_ENABLED[i] <= span_on(SPAN_CODES_IN[i*`CPDC_SPAN_W +: `CPDC_SPAN_W]);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
            MODE_LVDS <= 1'b0;
        else
            MODE_LVDS <= mode_sync[1];
    end

    // echoed clock toggles on request while chip select is low, forced low when busy falls
    always_ff @(posedge CLK)
    begin
        if (rst_any)
            ECHOED_SERIAL_CLOCK_OUT <= 1'b0;
        else if (busy_prev && !BUSY)
            ECHOED_SERIAL_CLOCK_OUT <= 1'b0;
        else if (ECHO_CLOCK_TOGGLE && !cs_sync[1])
            ECHOED_SERIAL_CLOCK_OUT <= ~ECHOED_SERIAL_CLOCK_OUT;
    end

    property p_start_busy;
        @(posedge CLK) disable iff (!RST_B)
        (state == cpdc_pkg::ST_IDLE && cnv_rise && !pd_sync[1] && !GLOBAL_RESET) |=> ##1 BUSY;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy did not rise after start");

    property p_busy_len;
        @(posedge CLK) disable iff (!RST_B || GLOBAL_RESET)
        $rose(BUSY) |-> BUSY [*8];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy dropped early");

    property p_pd_ignore;
        @(posedge CLK) disable iff (!RST_B)
        (state == cpdc_pkg::ST_PDN) |=> !$rose(status.busy);
    endproperty
    a_pd_ignore: assert property (p_pd_ignore) else $error("conversion began in power-down");

    property p_pd_wait;
        @(posedge CLK) disable iff (!RST_B || GLOBAL_RESET)
        (state == cpdc_pkg::ST_CONV && cnt != '0) |=> state != cpdc_pkg::ST_PDN;
    endproperty
    a_pd_wait: assert property (p_pd_wait) else $error("power-down cut a conversion");

    property p_greset;
        @(posedge CLK) disable iff (!RST_B)
        GLOBAL_RESET |=> (state == cpdc_pkg::ST_IDLE && !BUSY && !pd_armed);
    endproperty
    a_greset: assert property (p_greset) else $error("global reset did not clear state");

    property p_mode;
        @(posedge CLK) disable iff (!RST_B)
        $stable(mode_sync[1]) |=> MODE_LVDS == $past(mode_sync[1]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode output wrong");

    property p_hold_all;
        @(posedge CLK) disable iff (!RST_B)
        BUSY |-> (HOLD_CH == {`CPDC_NUM_CH{1'b1}});
    endproperty
    a_hold_all: assert property (p_hold_all) else $error("channels not held together");

    property p_span;
        @(posedge CLK) disable iff (!RST_B)
        $rose(BUSY) |-> SPAN_LATCHED == $past(SPAN_CODES_IN, 2);
    endproperty
    a_span: assert property (p_span) else $error("span codes not latched");

    property p_echo_low;
        @(posedge CLK) disable iff (!RST_B)
        $fell(BUSY) |=> !ECHOED_SERIAL_CLOCK_OUT;
    endproperty
    a_echo_low: assert property (p_echo_low) else $error("echoed clock not low after busy");

    property p_no_restart;
        @(posedge CLK) disable iff (!RST_B || GLOBAL_RESET)
        (state == cpdc_pkg::ST_CONV && cnt != '0) |=> cnt == $past(cnt) - 1'b1;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

    c_conv: cover property (@(posedge CLK) $fell(BUSY));
    c_pd_during: cover property (@(posedge CLK) state == cpdc_pkg::ST_CONV && pd_rise);
    c_greset: cover property (@(posedge CLK) GLOBAL_RESET);
    c_ignored: cover property (@(posedge CLK) state == cpdc_pkg::ST_CONV && cnv_rise);
endmodule : cpdc_top

// file: testbench/cpdc_host_model.sv
// host side model driving the conversion, power-down and mode pins
`timescale 1ns/1ns
`include "cpdc_consts.svh"
module cpdc_host_model (
    // clock
    input wire logic clk,
    // pins toward the converter
    output logic start,
    output logic pdn,
    output logic mode_lvds,
    output logic cs_b,
    output logic [`CPDC_NUM_CH*`CPDC_SPAN_W-1:0] spans,
    output logic echo_tgl
);
    initial
    begin
        start = 1'b0;
        pdn = 1'b0;
        mode_lvds = 1'b0;
        cs_b = 1'b1;
        spans = '0;
        echo_tgl = 1'b0;
    end

    // power-down, mode, chip select and span levels are all driven from the arguments on each call
    task automatic set_pins(input logic pd, input logic md, input logic cs, input logic [23:0] sp);
        pdn = pd;
        mode_lvds = md;
        cs_b = cs;
        spans = sp;
    endtask : set_pins

    // start held three cycles so the pin synchroniser sees the edge
    task automatic start_edge;
        start = 1'b1;
        repeat (3) @(negedge clk);
        start = 1'b0;
        repeat (3) @(negedge clk);
    endtask : start_edge

    task automatic echo_pulse;
        echo_tgl = 1'b1;
        @(negedge clk);
        echo_tgl = 1'b0;
    endtask : echo_pulse
endmodule : cpdc_host_model

// file: testbench/cpdc_tb_top.sv
// top testbench: random conversions, power-down and global reset
`timescale 1ns/1ns
`include "cpdc_consts.svh"
module cpdc_tb_top;
    localparam int CONV_N = 12;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic conversion_start_in, pdn, mode, cs_b, tgl;
    logic [`CPDC_NUM_CH*`CPDC_SPAN_W-1:0] spans, span_l;
    logic busy, pdd, grst, echo, mode_o;
    logic [`CPDC_NUM_CH-1:0] hold, chen;
    int checks_done = 0;
    int miscompares = 0;
    int seed = 32'hdf5e;
    int run = 0;
    int last_len = 0;
    int n_conv = 0;
    int n_grst = 0;
    int cyc = 0;
    int c0;

    always #50 clk = ~clk;

    cpdc_host_model host (.clk(clk), .start(conversion_start_in), .pdn(pdn), .mode_lvds(mode), .cs_b(cs_b),
        .spans(spans), .echo_tgl(tgl));

    cpdc_top #(.CONV_CYCLES(CONV_N)) cpdc_top_i (.CLK(clk), .RST_B(rst_b), .CONVERSION_START_IN(conversion_start_in),
        .POWER_DOWN_IN(pdn), .MODE_LVDS_IN(mode), .CHIP_SELECT_B_IN(cs_b), .SPAN_CODES_IN(spans),
        .ECHO_CLOCK_TOGGLE(tgl), .BUSY(busy), .HOLD_CH(hold), .SPAN_LATCHED(span_l), .CH_ENABLED(chen),
        .MODE_LVDS(mode_o), .POWERED_DOWN(pdd), .GLOBAL_RESET(grst), .ECHOED_SERIAL_CLOCK_OUT(echo));

    // busy run length, finished conversions, reset pulses and timeout
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (grst === 1'b1)
            n_grst <= n_grst + 1;
        if (busy === 1'b1)
            run <= run + 1;
        else if (run != 0)
        begin
            last_len <= run;
            n_conv <= n_conv + 1;
            run <= 0;
        end
        if (cyc == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    function automatic logic [23:0] exp_en(input logic [23:0] sp);
        logic [23:0] e = '0;
        for (int i = 0; i < `CPDC_NUM_CH; i++)
            e[i] = (sp[i*`CPDC_SPAN_W +: `CPDC_SPAN_W] != `CPDC_SPAN_DISABLED);
        return e;
    endfunction : exp_en

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_idle;
        int n = 0;
        while (busy === 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
    endtask : wait_idle

    // one conversion with random chip select and mode, optional second edge while busy
    task automatic conv(input bit again, input logic [23:0] sp);
        logic md = 1'($random(seed));
        logic cs = 1'($random(seed));
        int k = n_conv;
        host.set_pins(1'b0, md, cs, sp);
        host.start_edge();
        chk("hold", 24'(8'hff), 24'(hold));
        chk("span", sp, span_l);
        chk("enabled", exp_en(sp), 24'(chen));
        host.echo_pulse();
        chk("echo_tgl", 24'(!cs), 24'(echo));
        if (again)
            host.start_edge();
        wait_idle();
        chk("busy_len", 24'(CONV_N), 24'(last_len));
        chk("conv_count", 24'(k + 1), 24'(n_conv));
        chk("echo", 24'h0, 24'(echo));
        chk("mode", 24'(md), 24'(mode_o));
    endtask : conv

    task report_and_stop;
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        conv(1'b0, 24'h000000);
        conv(1'b1, 24'hffffff);
        repeat (8) conv(1'($random(seed)), 24'($random(seed)));
        // power-down raised in mid-conversion
        host.start_edge();
        host.set_pins(1'b1, mode, cs_b, spans);
        repeat (2) @(negedge clk);
        chk("pd_early", 24'h0, 24'(pdd));
        wait_idle();
        chk("pd_len", 24'(CONV_N), 24'(last_len));
        chk("pd_on", 24'h1, 24'(pdd));
        c0 = n_conv;
        host.start_edge();
        repeat (CONV_N) @(negedge clk);
        chk("pd_ignore", 24'(c0), 24'(n_conv));
        host.set_pins(1'b0, mode, cs_b, spans);
        repeat (6) @(negedge clk);
        chk("pd_off", 24'h0, 24'(pdd));
        conv(1'b0, 24'($random(seed)));
        // two raises with no conversion between them
        host.set_pins(1'b1, mode, cs_b, spans);
        repeat (6) @(negedge clk);
        chk("grst_none", 24'h0, 24'(n_grst));
        host.set_pins(1'b0, mode, cs_b, spans);
        repeat (6) @(negedge clk);
        host.set_pins(1'b1, mode, cs_b, spans);
        repeat (12) @(negedge clk);
        chk("grst_once", 24'h1, 24'(n_grst));
        chk("grst_span", 24'hffffff, span_l);
        host.set_pins(1'b0, mode, cs_b, spans);
        repeat (6) @(negedge clk);
        conv(1'b0, 24'($random(seed)));
        report_and_stop();
    end
endmodule : cpdc_tb_top
